// ---- chopsel.sv ----
// Chopper mode and standstill selection for one motor axis.
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "chopsel_cfg.svh"

// Overview of one axis.
// The block sits between the host's parameter store and the power stage.
// It holds the settings of one motor axis in a small register file.
// It watches the actual speed and the standstill indication of that axis.
// From these it decides, every clock, which chopper the power stage uses.
// It also decides how the coils are treated once the shaft is at rest.
// The result leaves as one packed command word and one status flag.
//
// Register file.
// Index 0 holds the PWM gradient; zero keeps quiet mode switched off.
// Index 1 holds the PWM threshold speed; faster than this is never quiet.
// Index 2 holds the current-adaptation threshold speed.
// That threshold limits quiet mode even when adaptation is not in use.
// Index 3 holds the fullstep threshold speed; quiet mode needs less.
// Its reset value is the largest speed, so by default it only limits at that speed.
// Index 4 holds the PWM frequency code handed to the power stage.
// Index 5 holds the PWM autoscale enable, which is on after reset.
// Index 6 holds the standstill treatment code.
// Index 7 holds the standby current used at rest.
// Index 8 holds the run current used while the shaft turns.
// Index 9 is the read-only status word.
// Status bit 0 shows quiet mode in use; bit 1 mirrors the rest input.
// Writes to index 9 or to any unmapped index are dropped.
// Reads of unmapped indices return zero.
//
// Register bus timing.
// A write strobe stores its data at the edge that samples it.
// A read strobe loads the read data at the edge that samples it.
// The read data then stand for that one cycle and fall back to zero.
// The bus never stalls, so strobes may follow each other back to back.
// Write and read strobes must not be raised in the same cycle.
//
// Quiet mode decision.
// Quiet mode needs a nonzero gradient.
// It also needs the speed at or below the PWM threshold.
// It also needs the speed at or below the adaptation threshold.
// It also needs the speed strictly below the fullstep threshold.
// With zero PWM and adaptation thresholds a resting shaft may therefore still run quiet.
// That is what makes the open and shorted treatments reachable at rest.
// The decision is registered inside the speed comparator.
// A change of speed thus reaches the outputs two edges later.
// A change of gradient or threshold reaches the outputs two edges after its write; other settings take one edge.
//
// Standstill treatment.
// Code 0 keeps the chopper running and lowers the current to standby.
// Code 1 opens all coils so that the shaft turns freely.
// Code 2 shorts the coils through the low-side drivers.
// Code 3 shorts the coils through the high-side drivers.
// Codes 1 to 3 only take effect in quiet mode with a zero standby current.
// In every other case the plain standby current is applied at rest.
// The open and shorted treatments always command zero current.
// Quiet mode stays flagged while one of these treatments is applied.
//
// Hazards and limits.
// The speed and rest inputs must come from logic on this same clock.
// They are not synchronised here, so a pin must never feed them directly.
// Only one of the open and shorted treatments can be commanded at once.
// The command word only changes at a clock edge or when reset is asserted, never otherwise.
// A threshold change takes effect without any host handshake.
// The host has no mode select; a zero gradient forces normal chopping, otherwise it can only move the thresholds.
// The speed width may be narrowed, but never widened past the bus fields.

module chopsel
#(
  parameter int SPEED_W = 24
)
(
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic [3:0]         addr,
  input  wire logic [31:0]        wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  output logic [31:0]             rdata,
  input  wire logic [SPEED_W-1:0] actual_speed,
  input  wire logic               standstill,
  output chopsel_pkg::drive_cmd_t drive_cmd,
  output logic                    quiet_active
);

  // Speeds wider than the register fields cannot be stored or read back.
  generate
    if (SPEED_W < 1 || SPEED_W > 24)
    begin : bad_speed_w
      $error("SPEED_W must lie between 1 and 24");
    end
  endgenerate

  logic [3:0]         grad_q;
  logic [SPEED_W-1:0] pwm_thrs_q;
  logic [SPEED_W-1:0] adapt_thrs_q;
  logic [SPEED_W-1:0] full_thrs_q;
  logic [1:0]         freq_q;
  logic               autoscale_q;
  chopsel_pkg::still_mode_t still_q;
  logic [7:0]         stby_q;
  logic [7:0]         run_q;
  logic               quiet_ok;
  chopsel_pkg::drive_state_t state_d;
  chopsel_pkg::drive_state_t state_q;
  chopsel_pkg::drive_cmd_t   cmd_d;

  // Pads a field into a read word with zero upper bits.
  function automatic logic [31:0] pad24(input logic [SPEED_W-1:0] v);
    logic [31:0] r;
    r = 32'h0;
    r[SPEED_W-1:0] = v;
    return r;
  endfunction

  // True when the write strobe selects the given register index.
  function automatic logic write_hit(input logic       w,
                                     input logic [3:0] at,
                                     input logic [3:0] a);
    return w && (at == a);
  endfunction

  // Gradient setting; zero keeps quiet mode off.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      grad_q <= `RST_PWM_GRAD;
    else if (write_hit(wr, addr, `ADDR_PWM_GRAD))
      grad_q <= wdata[3:0];
  end

  // PWM threshold speed.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      pwm_thrs_q <= SPEED_W'(`RST_PWM_THRS);
    else if (write_hit(wr, addr, `ADDR_PWM_THRS))
      pwm_thrs_q <= wdata[SPEED_W-1:0];
  end

  // Current-adaptation threshold speed.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      adapt_thrs_q <= SPEED_W'(`RST_ADAPT_THRS);
    else if (write_hit(wr, addr, `ADDR_ADAPT_THRS))
      adapt_thrs_q <= wdata[SPEED_W-1:0];
  end

  // Fullstep threshold speed, limiting only at the largest speed after reset.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      full_thrs_q <= SPEED_W'(`RST_FULL_THRS);
    else if (write_hit(wr, addr, `ADDR_FULL_THRS))
      full_thrs_q <= wdata[SPEED_W-1:0];
  end

  // PWM frequency code for quiet mode.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      freq_q <= `RST_PWM_FREQ;
    else if (write_hit(wr, addr, `ADDR_PWM_FREQ))
      freq_q <= wdata[1:0];
  end

  // Autoscale enable, on after reset.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      autoscale_q <= `RST_AUTOSCALE;
    else if (write_hit(wr, addr, `ADDR_AUTOSCALE))
      autoscale_q <= wdata[0];
  end

  // Standstill treatment code.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      still_q <= chopsel_pkg::STILL_STANDBY;
    else if (write_hit(wr, addr, `ADDR_STILL_MODE))
      still_q <= chopsel_pkg::still_mode_t'(wdata[1:0]);
  end

  // Standby current applied at rest.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      stby_q <= `RST_STBY_CUR;
    else if (write_hit(wr, addr, `ADDR_STBY_CUR))
      stby_q <= wdata[7:0];
  end

  // Run current applied while the shaft turns.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      run_q <= `RST_RUN_CUR;
    else if (write_hit(wr, addr, `ADDR_RUN_CUR))
      run_q <= wdata[7:0];
  end

  // Read data stands in the cycle after the strobe only.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata <= 32'h0;
    else if (rd)
    begin
      unique case (addr)
        `ADDR_PWM_GRAD:   rdata <= {28'h0, grad_q};
        `ADDR_PWM_THRS:   rdata <= pad24(pwm_thrs_q);
        `ADDR_ADAPT_THRS: rdata <= pad24(adapt_thrs_q);
        `ADDR_FULL_THRS:  rdata <= pad24(full_thrs_q);
        `ADDR_PWM_FREQ:   rdata <= {30'h0, freq_q};
        `ADDR_AUTOSCALE:  rdata <= {31'h0, autoscale_q};
        `ADDR_STILL_MODE: rdata <= {30'h0, still_q};
        `ADDR_STBY_CUR:   rdata <= {24'h0, stby_q};
        `ADDR_RUN_CUR:    rdata <= {24'h0, run_q};
        `ADDR_STATUS:     rdata <= {30'h0, standstill, quiet_active};
        default:          rdata <= 32'h0;
      endcase
    end
    else
      rdata <= 32'h0;
  end

  speed_gate
  #(
    .SPEED_W (SPEED_W)
  )
  u_gate
  (
    .clk        (clk),
    .rst_b      (rst_b),
    .speed      (actual_speed),
    .grad       (grad_q),
    .pwm_thrs   (pwm_thrs_q),
    .adapt_thrs (adapt_thrs_q),
    .full_thrs  (full_thrs_q),
    .quiet_ok   (quiet_ok)
  );

  // Drive state from the quiet decision and the standstill treatment.
  always_comb
  begin
    state_d = quiet_ok ? chopsel_pkg::DRV_QUIET_PWM
                       : chopsel_pkg::DRV_NORMAL_CHOP;
    if (standstill && quiet_ok && stby_q == 8'h00)
    begin
      unique case (still_q)
        chopsel_pkg::STILL_FREE:     state_d = chopsel_pkg::DRV_OPEN;
        chopsel_pkg::STILL_LS_SHORT: state_d = chopsel_pkg::DRV_SHORT_LOW;
        chopsel_pkg::STILL_HS_SHORT: state_d = chopsel_pkg::DRV_SHORT_HIGH;
        chopsel_pkg::STILL_STANDBY:  ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state_q <= chopsel_pkg::DRV_NORMAL_CHOP;
    else
      state_q <= state_d;
  end

  // Command bundle for the power stage.
  always_comb
  begin
    cmd_d            = '0;
    cmd_d.pwm_freq   = freq_q;
    cmd_d.autoscale  = autoscale_q;
    cmd_d.current    = standstill ? stby_q : run_q;
    unique case (state_d)
      chopsel_pkg::DRV_NORMAL_CHOP: ;
      chopsel_pkg::DRV_QUIET_PWM:  cmd_d.quiet_pwm = 1'b1;
      chopsel_pkg::DRV_OPEN:
      begin
        cmd_d.quiet_pwm = 1'b1;
        cmd_d.current   = 8'h00;
        cmd_d.coils_off = 1'b1;
      end
      chopsel_pkg::DRV_SHORT_LOW:
      begin
        cmd_d.quiet_pwm = 1'b1;
        cmd_d.current   = 8'h00;
        cmd_d.short_low = 1'b1;
      end
      chopsel_pkg::DRV_SHORT_HIGH:
      begin
        cmd_d.quiet_pwm  = 1'b1;
        cmd_d.current    = 8'h00;
        cmd_d.short_high = 1'b1;
      end
      default: ;
    endcase
  end

  // Command word to the power stage, straight from a flip-flop.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      drive_cmd <= '0;
    else
      drive_cmd <= cmd_d;
  end

  // Quiet mode flag, kept in step with the command word.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      quiet_active <= 1'b0;
    else
      quiet_active <= cmd_d.quiet_pwm;
  end

endmodule

`default_nettype wire

// ---- chopsel_cfg.svh ----
// Constants for the chopper mode and standstill selection block.
`ifndef CHOPSEL_CFG_SVH
`define CHOPSEL_CFG_SVH

// Register offsets.
`define ADDR_PWM_GRAD     4'h0
`define ADDR_PWM_THRS     4'h1
`define ADDR_ADAPT_THRS   4'h2
`define ADDR_FULL_THRS    4'h3
`define ADDR_PWM_FREQ     4'h4
`define ADDR_AUTOSCALE    4'h5
`define ADDR_STILL_MODE   4'h6
`define ADDR_STBY_CUR     4'h7
`define ADDR_RUN_CUR      4'h8
`define ADDR_STATUS       4'h9

// Reset values.
`define RST_PWM_GRAD      4'h0
`define RST_PWM_THRS      24'h000000
`define RST_ADAPT_THRS    24'h000000
`define RST_FULL_THRS     24'hffffff
`define RST_PWM_FREQ      2'h0
`define RST_AUTOSCALE     1'h1
`define RST_STILL_MODE    2'h0
`define RST_STBY_CUR      8'h00
`define RST_RUN_CUR       8'hff

// Status field positions.
`define STAT_PWM_BIT      0
`define STAT_STILL_BIT    1

`endif

// ---- chopsel_pkg.sv ----
// Types for the chopper mode and standstill selection block.
package chopsel_pkg;

  typedef enum logic [1:0]
  {
    STILL_STANDBY = 2'h0,
    STILL_FREE    = 2'h1,
    STILL_LS_SHORT = 2'h2,
    STILL_HS_SHORT = 2'h3
  } still_mode_t;

  typedef enum logic [2:0]
  {
    DRV_NORMAL_CHOP,
    DRV_QUIET_PWM,
    DRV_OPEN,
    DRV_SHORT_LOW,
    DRV_SHORT_HIGH
  } drive_state_t;

  // Driver command bundle handed to the power stage.
  typedef struct packed
  {
    logic       quiet_pwm;
    logic [1:0] pwm_freq;
    logic       autoscale;
    logic [7:0] current;
    logic       coils_off;
    logic       short_low;
    logic       short_high;
  } drive_cmd_t;

endpackage

// ---- speed_gate.sv ----
// Speed comparator deciding whether quiet PWM chopping may be used.
`timescale 1ns/1ps
`default_nettype none

module speed_gate
#(
  parameter int SPEED_W = 24
)
(
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic [SPEED_W-1:0] speed,
  input  wire logic [3:0]         grad,
  input  wire logic [SPEED_W-1:0] pwm_thrs,
  input  wire logic [SPEED_W-1:0] adapt_thrs,
  input  wire logic [SPEED_W-1:0] full_thrs,
  output logic                    quiet_ok
);

  logic ok_d;

  // All three thresholds and a nonzero gradient must admit quiet mode.
  always_comb
  begin
    ok_d = (grad != 4'h0);
    if (speed > pwm_thrs)
      ok_d = 1'b0;
    if (speed > adapt_thrs)
      ok_d = 1'b0;
    if (speed >= full_thrs)
      ok_d = 1'b0;
  end

  // Registered every cycle so the decision tracks speed on its own.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      quiet_ok <= 1'b0;
    else
      quiet_ok <= ok_d;
  end

endmodule

`default_nettype wire

// ---- chopsel_properties.sv ----
// Port-level checks for the chopper mode selection block.
`timescale 1ns/1ps
`default_nettype none

module chopsel_properties
#(
  parameter int SPEED_W = 24
)
(
  input wire logic                    clk,
  input wire logic                    rst_b,
  input wire logic [3:0]              addr,
  input wire logic [31:0]             wdata,
  input wire logic                    wr,
  input wire logic                    rd,
  input wire logic [31:0]             rdata,
  input wire logic [SPEED_W-1:0]      actual_speed,
  input wire logic                    standstill,
  input wire chopsel_pkg::drive_cmd_t drive_cmd,
  input wire logic                    quiet_active
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Standstill treatment bits and the written frequency field.
  wire logic [2:0] stop = {drive_cmd.coils_off, drive_cmd.short_low,
                           drive_cmd.short_high};
  wire logic [1:0] wfreq = wdata[1:0];

  // A setting written, then left alone for three cycles.
  sequence grad_zeroed;
    wr && addr == 4'h0 && wdata[3:0] == 4'h0 ##1 !(wr && addr == 4'h0) [*3];
  endsequence
  sequence freq_set;
    wr && addr == 4'h4 ##1 !(wr && addr == 4'h4) [*3];
  endsequence

  a_rdata_idle: assert property (!rd |=> rdata == 32'h0)
    else $error("read data not idle");
  a_status_read: assert property (rd && addr == 4'h9 |=>
    rdata == {30'h0, $past(standstill), $past(quiet_active)})
    else $error("status read wrong");
  a_flag_mirror: assert property (quiet_active == drive_cmd.quiet_pwm)
    else $error("flag differs from command");
  a_grad_off: assert property (grad_zeroed |-> !quiet_active)
    else $error("quiet mode with zero gradient");
  a_freq_follow: assert property (freq_set |->
    drive_cmd.pwm_freq == $past(wfreq, 3))
    else $error("frequency not applied");
  a_max_speed: assert property (actual_speed == '1 |-> ##2 !quiet_active)
    else $error("quiet mode at full speed");
  a_stop_quiet: assert property (|stop |->
    quiet_active && drive_cmd.current == 8'h00)
    else $error("stop treatment without quiet mode");
  a_stop_moving: assert property (!standstill |=> stop == 3'h0)
    else $error("stop treatment while moving");
  a_stop_single: assert property ($onehot0(stop))
    else $error("several stop treatments");
endmodule

bind chopsel chopsel_properties #(.SPEED_W(SPEED_W)) chopsel_properties_inst
(
  .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .actual_speed(actual_speed), .standstill(standstill),
  .drive_cmd(drive_cmd), .quiet_active(quiet_active)
);
`default_nettype wire

// ---- motor_coils.sv ----
// Motor model: actual speed follows the target, zero speed means rest.
`timescale 1ns/1ps
`default_nettype none

module motor_coils
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [23:0] target,
  output logic      [23:0] speed,
  output logic             still
);
  // The shaft reaches the target one cycle after it is set.
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      speed <= 24'h0;
    else
      speed <= target;

  // Rest is reported whenever the shaft is not turning.
  assign still = (speed == 24'h0);
endmodule
`default_nettype wire

// ---- test_chopsel.sv ----
// Self-checking bench for the chopper mode selection block.
`timescale 1ns/1ps
`default_nettype none

module test_chopsel;
  logic                    clk = 1'h0;
  logic                    rst_b = 1'h0;
  logic [3:0]              addr = 4'h0;
  logic [31:0]             wdata = 32'h0;
  logic                    wr = 1'h0;
  logic                    rd = 1'h0;
  logic [31:0]             rdata;
  logic [23:0]             target = 24'h0;
  logic [23:0]             speed;
  logic                    still;
  chopsel_pkg::drive_cmd_t cmd;
  logic                    quiet;
  logic [1:0]              freq_v = 2'h0;
  logic                    auto_v = 1'h1;
  int                      errors = 0;
  int                      n_tests = 0;
  int                      cyc = 0;

  // Clock of 20 ns.
  always #10 clk = ~clk;

  chopsel chopsel_inst (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .actual_speed(speed),
    .standstill(still), .drive_cmd(cmd), .quiet_active(quiet));
  motor_coils motor_coils_inst (.clk(clk), .rst_b(rst_b), .target(target),
    .speed(speed), .still(still));

  task automatic results();
    if (errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Cuts a hung run short.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      results();
    end
  end

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    n_tests++;
    if (rdata !== exp)
    begin
      errors++;
      $display("[FAIL] %0t read %h got %h", $time, a, rdata);
    end
  endtask

  task automatic spd(input logic [23:0] v);
    @(posedge clk);
    target <= v;
  endtask

  // Lets speed or settings settle, then compares the drive command.
  task automatic cmd_chk(input logic q, input logic [7:0] c,
                         input logic [2:0] s);
    chopsel_pkg::drive_cmd_t exp;
    exp = {q, freq_v, auto_v, c, s};
    repeat (4) @(posedge clk);
    #1;
    n_tests++;
    if (cmd !== exp || quiet !== q)
    begin
      errors++;
      $display("[FAIL] %0t drive got %h", $time, cmd);
    end
  endtask

  // Main sequence.
  initial
  begin
    repeat (12) @(posedge clk);
    rst_b <= 1'h1;
    cmd_chk(1'h0, 8'h00, 3'h0);
    rd_chk(4'h3, 32'hffffff);
    rd_chk(4'ha, 32'h0);
    wr_reg(4'h9, 32'h1);
    rd_chk(4'h9, 32'h2);
    spd(24'h001388);
    cmd_chk(1'h0, 8'hff, 3'h0);
    wr_reg(4'h0, 32'hf);
    wr_reg(4'h1, 32'h1388);
    wr_reg(4'h2, 32'h1388);
    cmd_chk(1'h1, 8'hff, 3'h0);
    rd_chk(4'h9, 32'h1);
    spd(24'h001389);
    cmd_chk(1'h0, 8'hff, 3'h0);
    wr_reg(4'h1, 32'h2000);
    cmd_chk(1'h0, 8'hff, 3'h0);
    wr_reg(4'h2, 32'h2000);
    cmd_chk(1'h1, 8'hff, 3'h0);
    wr_reg(4'h3, 32'h1389);
    cmd_chk(1'h0, 8'hff, 3'h0);
    wr_reg(4'h3, 32'hffffff);
    spd(24'hffffff);
    cmd_chk(1'h0, 8'hff, 3'h0);
    spd(24'h001389);
    for (int m = 0; m < 4; m++)
    begin
      wr_reg(4'h4, 32'(m));
      freq_v = 2'(m);
      cmd_chk(1'h1, 8'hff, 3'h0);
    end
    wr_reg(4'h5, 32'h0);
    auto_v = 1'h0;
    cmd_chk(1'h1, 8'hff, 3'h0);
    spd(24'h0);
    for (int m = 0; m < 4; m++)
    begin
      wr_reg(4'h6, 32'(m));
      cmd_chk(1'h1, 8'h00, m == 0 ? 3'h0 : 3'(4 >> (m - 1)));
    end
    rd_chk(4'h9, 32'h3);
    wr_reg(4'h7, 32'h20);
    cmd_chk(1'h1, 8'h20, 3'h0);
    wr_reg(4'h7, 32'h0);
    wr_reg(4'h0, 32'h0);
    cmd_chk(1'h0, 8'h00, 3'h0);
    wr_reg(4'h0, 32'hf);
    spd(24'h000010);
    cmd_chk(1'h1, 8'hff, 3'h0);
    results();
  end
endmodule
`default_nettype wire
